// File: rtl/counter_array_regs.svh
// Notes on behaviour
// - five 16-bit capture/compare modules share one common counter as time base.
// - counter advances from osc/12, osc/4, timer 0 overflow or external count input.
// - with idle halt set, counter stops while the processor idles.
// - module 4 guard enable turns module 4 watchdog function on or off.
// - counter runs only while counter run (control bit 6) is set.
// - overflow sets control bit 7; interrupt if enabled; software alone clears it.
// - control bits 0..4 are module event flags, set by hardware, cleared by software.
// - module mode bit 0 enables module interrupt together with its event flag.
// - module mode bit 1 enables pulse width modulation.
// - mode bit 2 inverts the module pin when counter equals compare value.
// - mode bit 3 sets the module event flag on counter match.
// - bit 4 captures falling edges, bit 5 rising; both capture either edge.
// - mode bit 6 enables the comparator against the stored value.
// - on an enabled pin edge, counter high and low bytes copy into stored value.
// - comparator plus match flag enable form the software timer mode.
// - invert, match flag and comparator enables form high-speed output mode.
// - in pulse width mode stored high and low bytes set the duty cycle.
// - pwm low while counter low below stored low; reload low from high on wrap.
// - pwm needs pwm and comparator enables; all modules share one frequency.
`ifndef COUNTER_ARRAY_REGS_SVH
`define COUNTER_ARRAY_REGS_SVH

`define CA_ADDR_MODE 8'h00
`define CA_ADDR_CTRL 8'h04
`define CA_ADDR_CNT 8'h08
`define CA_ADDR_IRQ 8'h0c
`define CA_ADDR_MMODE0 8'h10
`define CA_ADDR_STORE0 8'h30

`define CA_CTRL_OVF 7
`define CA_CTRL_RUN 6
`define CA_MODE_OVF_IE 0
`define CA_MODE_SRC_LO 1
`define CA_MODE_SRC_HI 2
`define CA_MODE_GUARD 6
`define CA_MODE_IDLE 7
`define CA_MM_IE 0
`define CA_MM_PWM 1
`define CA_MM_TOG 2
`define CA_MM_MAT 3
`define CA_MM_FALLING_EDGE_CAPTURE_ENABLE 4
`define CA_MM_RISING_EDGE_CAPTURE_ENABLE 5
`define CA_MM_COMPARATOR_ENABLE 6

`define CA_RESET_BYTE 8'h00
`define CA_DIV12 4'd11
`define CA_DIV4 4'd3

`endif

// File: rtl/counter_array_pkg.sv
`default_nettype none
package counter_array_pkg;
  typedef enum logic [1:0] {
    SRC_DIV12,
    SRC_DIV4,
    SRC_T0_OVF,
    SRC_EXT
  } count_source_t;

  typedef enum logic [1:0] {
    AXI_IDLE,
    AXI_RESP
  } bus_state_t;
endpackage : counter_array_pkg
`default_nettype wire

// File: rtl/counter_array.sv
`include "counter_array_regs.svh"
`default_nettype none
module counter_array
  import counter_array_pkg::*;
#(
  parameter int N_MOD = 5
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system
  input wire logic cpu_idle,
  input wire logic timer0_overflow,
  input wire logic external_count_input,
  // module pins
  input wire logic [N_MOD-1:0] module_pin_in,
  output logic [N_MOD-1:0] module_pin_out,
  output logic [N_MOD-1:0] module_pin_oe,
  // request lines
  output logic irq,
  output logic module4_guard_hit
);

  typedef struct packed {
    logic [7:0] array_mode_reg;
    logic [7:0] array_control_reg;
    logic [15:0] counter;
    logic [3:0] prescale;
    logic ext_prev;
    logic [N_MOD-1:0] pin_prev;
    logic [N_MOD-1:0][7:0] module_mode_reg;
    logic [N_MOD-1:0][7:0] module_stored_high;
    logic [N_MOD-1:0][7:0] module_stored_low;
    logic [N_MOD-1:0] pin_q;
    logic guard_hit;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;

  state_t state_q;
  state_t state_d;

  count_source_t src;
  logic tick;
  logic wr_fire;
  logic wr_ok;
  logic [31:0] rd_val;
  logic rd_ok;
  logic [7:0] counter_low_byte;
  logic [7:0] counter_high_byte;

  assign src = count_source_t'({state_q.array_mode_reg[`CA_MODE_SRC_HI],
                                state_q.array_mode_reg[`CA_MODE_SRC_LO]});
  assign counter_low_byte = state_q.counter[7:0];
  assign counter_high_byte = state_q.counter[15:8];

  // source tick, one cycle wide except for timer 0 overflow, which follows the timer0_overflow level
  always_comb begin
    unique case (src)
      SRC_DIV12: tick = (state_q.prescale == `CA_DIV12);
      SRC_DIV4: tick = (state_q.prescale[1:0] == 2'(`CA_DIV4));
      SRC_T0_OVF: tick = timer0_overflow;
      SRC_EXT: tick = external_count_input & ~state_q.ext_prev;
    endcase
  end

  // read decode
  always_comb begin
    int idx;
    idx = 0;
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == `CA_ADDR_MODE) begin
      rd_val[7:0] = state_q.array_mode_reg;
    end else if (s_axi_araddr == `CA_ADDR_CTRL) begin
      rd_val[7:0] = state_q.array_control_reg;
    end else if (s_axi_araddr == `CA_ADDR_CNT) begin
      rd_val[15:0] = {counter_high_byte, counter_low_byte};
    end else if (s_axi_araddr == `CA_ADDR_IRQ) begin
      rd_val[0] = irq;
      rd_val[1] = state_q.guard_hit;
      rd_val[8 +: N_MOD] = state_q.pin_q;
    end else if (s_axi_araddr >= `CA_ADDR_MMODE0 &&
                 s_axi_araddr < `CA_ADDR_MMODE0 + 8'(4 * N_MOD)) begin
      idx = int'(s_axi_araddr - `CA_ADDR_MMODE0) >> 2;
      rd_val[7:0] = state_q.module_mode_reg[idx];
    end else if (s_axi_araddr >= `CA_ADDR_STORE0 &&
                 s_axi_araddr < `CA_ADDR_STORE0 + 8'(4 * N_MOD)) begin
      idx = int'(s_axi_araddr - `CA_ADDR_STORE0) >> 2;
      rd_val[15:0] = {state_q.module_stored_high[idx], state_q.module_stored_low[idx]};
    end else begin
      rd_ok = 1'b0;
    end
    if (s_axi_araddr[1:0] != 2'b00) begin
      rd_ok = 1'b0;
    end
  end

  assign wr_fire = state_q.aw_got & state_q.w_got & ~state_q.bvalid;
  assign wr_ok = (state_q.aw_addr[1:0] == 2'b00) &&
                 (state_q.aw_addr <= `CA_ADDR_CNT ||
                  (state_q.aw_addr >= `CA_ADDR_MMODE0 &&
                   state_q.aw_addr < `CA_ADDR_MMODE0 + 8'(4 * N_MOD)) ||
                  (state_q.aw_addr >= `CA_ADDR_STORE0 &&
                   state_q.aw_addr < `CA_ADDR_STORE0 + 8'(4 * N_MOD)));

  always_comb begin
    int m;
    logic running;
    logic wrap;
    logic [7:0] mm;
    logic hit;
    logic cap;
    logic [15:0] stored;
    m = 0;
    mm = 8'h00;
    hit = 1'b0;
    cap = 1'b0;
    stored = 16'h0000;
    state_d = state_q;

    // prescaler runs free, whatever the count source
    state_d.prescale = (state_q.prescale == `CA_DIV12) ? 4'h0 : state_q.prescale + 4'h1;
    state_d.ext_prev = external_count_input;
    state_d.pin_prev = module_pin_in;

    running = state_q.array_control_reg[`CA_CTRL_RUN] &
              ~(state_q.array_mode_reg[`CA_MODE_IDLE] & cpu_idle);
    wrap = running & tick & (state_q.counter == 16'hffff);
    if (running && tick) begin
      state_d.counter = state_q.counter + 16'h0001;
    end
    if (wrap) begin
      state_d.array_control_reg[`CA_CTRL_OVF] = 1'b1;
    end
    state_d.guard_hit = 1'b0;

    for (m = 0; m < N_MOD; m++) begin
      mm = state_q.module_mode_reg[m];
      stored = {state_q.module_stored_high[m], state_q.module_stored_low[m]};
      hit = mm[`CA_MM_COMPARATOR_ENABLE] & running & tick & (state_q.counter == stored);
      cap = (mm[`CA_MM_RISING_EDGE_CAPTURE_ENABLE] & module_pin_in[m] & ~state_q.pin_prev[m]) |
            (mm[`CA_MM_FALLING_EDGE_CAPTURE_ENABLE] & ~module_pin_in[m] & state_q.pin_prev[m]);
      if (mm[`CA_MM_PWM] && mm[`CA_MM_COMPARATOR_ENABLE]) begin
        // duty from low byte; high byte buffers next duty so updates stay glitch free
        state_d.pin_q[m] = (counter_low_byte >= state_q.module_stored_low[m]);
        if (running && tick && counter_low_byte == 8'hff) begin
          state_d.module_stored_low[m] = state_q.module_stored_high[m];
        end
      end else begin
        if (hit && mm[`CA_MM_TOG]) begin
          state_d.pin_q[m] = ~state_q.pin_q[m];
        end
        if ((hit && mm[`CA_MM_MAT]) || cap) begin
          state_d.array_control_reg[m] = 1'b1;
        end
        if (cap) begin
          state_d.module_stored_high[m] = counter_high_byte;
          state_d.module_stored_low[m] = counter_low_byte;
        end
        if (m == 4 && hit && mm[`CA_MM_MAT] && state_q.array_mode_reg[`CA_MODE_GUARD]) begin
          state_d.guard_hit = 1'b1;
        end
      end
    end

    // axi write side
    if (s_axi_awvalid && !state_q.aw_got) begin
      state_d.aw_got = 1'b1;
      state_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_q.w_got) begin
      state_d.w_got = 1'b1;
      state_d.w_data = s_axi_wdata;
      state_d.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      state_d.aw_got = 1'b0;
      state_d.w_got = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = wr_ok ? 2'b00 : 2'b10;
      if (state_q.w_strb[0]) begin
        if (state_q.aw_addr == `CA_ADDR_MODE) begin
          state_d.array_mode_reg = state_q.w_data[7:0];
        end else if (state_q.aw_addr == `CA_ADDR_CTRL) begin
          // flags clear only by writing 0; a same-cycle hardware set wins only for a flag that was clear
          state_d.array_control_reg = (state_q.w_data[7:0] & state_q.array_control_reg) |
                                      (state_d.array_control_reg & ~state_q.array_control_reg);
          state_d.array_control_reg[`CA_CTRL_RUN] = state_q.w_data[`CA_CTRL_RUN];
        end else if (state_q.aw_addr == `CA_ADDR_CNT) begin
          state_d.counter[7:0] = state_q.w_data[7:0];
        end
        for (m = 0; m < N_MOD; m++) begin
          if (state_q.aw_addr == `CA_ADDR_MMODE0 + 8'(4 * m)) begin
            state_d.module_mode_reg[m] = state_q.w_data[7:0] & 8'h7f;
          end
          if (state_q.aw_addr == `CA_ADDR_STORE0 + 8'(4 * m)) begin
            state_d.module_stored_low[m] = state_q.w_data[7:0];
          end
        end
      end
      if (state_q.w_strb[1]) begin
        if (state_q.aw_addr == `CA_ADDR_CNT) begin
          state_d.counter[15:8] = state_q.w_data[15:8];
        end
        for (m = 0; m < N_MOD; m++) begin
          if (state_q.aw_addr == `CA_ADDR_STORE0 + 8'(4 * m)) begin
            state_d.module_stored_high[m] = state_q.w_data[15:8];
          end
        end
      end
    end
    if (state_q.bvalid && s_axi_bready) begin
      state_d.bvalid = 1'b0;
    end

    // axi read side
    if (s_axi_arvalid && !state_q.rvalid) begin
      state_d.rvalid = 1'b1;
      state_d.rdata = rd_ok ? rd_val : 32'h0000_0000;
      state_d.rresp = rd_ok ? 2'b00 : 2'b10;
    end else if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  assign s_axi_awready = ~state_q.aw_got & clk_en;
  assign s_axi_wready = ~state_q.w_got & clk_en;
  assign s_axi_bvalid = state_q.bvalid;
  assign s_axi_bresp = state_q.bresp;
  assign s_axi_arready = ~state_q.rvalid & clk_en;
  assign s_axi_rvalid = state_q.rvalid;
  assign s_axi_rresp = state_q.rresp;
  assign s_axi_rdata = state_q.rdata;

  // pin driven only while the module uses it as an output
  always_comb begin
    for (int k = 0; k < N_MOD; k++) begin
      module_pin_oe[k] = state_q.module_mode_reg[k][`CA_MM_COMPARATOR_ENABLE] &
                         (state_q.module_mode_reg[k][`CA_MM_PWM] |
                          state_q.module_mode_reg[k][`CA_MM_TOG]);
    end
  end
  assign module_pin_out = state_q.pin_q;
  assign module4_guard_hit = state_q.guard_hit;

  always_comb begin
    irq = state_q.array_control_reg[`CA_CTRL_OVF] &
          state_q.array_mode_reg[`CA_MODE_OVF_IE];
    for (int k = 0; k < N_MOD; k++) begin
      irq = irq | (state_q.array_control_reg[k] &
                   state_q.module_mode_reg[k][`CA_MM_IE]);
    end
  end

endmodule : counter_array
`default_nettype wire

// File: tb/counter_array_checker.sv
`default_nettype none
module counter_array_checker #(
  parameter int N_MOD = 5
) (
  // clock, reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // pins and requests
  input wire logic [N_MOD-1:0] module_pin_out,
  input wire logic [N_MOD-1:0] module_pin_oe,
  input wire logic irq,
  input wire logic module4_guard_hit
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_resp_time_a: assert property (wr_taken_s |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  rd_resp_time_a: assert property (rd_taken_s |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response not on time");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped or changed");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  freeze_ready_a: assert property (!clk_en |-> !(s_axi_awready || s_axi_wready || s_axi_arready))
    else $error("bus ready while frozen");
  reset_clear_a: assert property ($rose(rst_n) |-> !irq && !module4_guard_hit
    && module_pin_out == '0 && module_pin_oe == '0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not cleared by reset");
  oe_by_write_a: assert property ($changed(module_pin_oe) |-> ##[0:1] s_axi_bvalid)
    else $error("pin drive changed without a write");
  guard_pulse_a: assert property (module4_guard_hit |=> !module4_guard_hit)
    else $error("guard hit longer than one cycle");
endmodule : counter_array_checker

bind counter_array counter_array_checker #(.N_MOD(N_MOD)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .module_pin_out(module_pin_out), .module_pin_oe(module_pin_oe),
  .irq(irq), .module4_guard_hit(module4_guard_hit)
);
`default_nettype wire

// File: tb/pin_model.sv
`default_nettype none
module pin_model (
  // bench levels
  input wire logic [4:0] pin_lvl,
  input wire logic ext_lvl,
  // block side
  input wire logic [4:0] module_pin_out,
  input wire logic [4:0] module_pin_oe,
  output logic [4:0] module_pin_in,
  output logic external_count_input
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pad reads back what the block drives
  assign module_pin_in = (module_pin_oe & module_pin_out) | (~module_pin_oe & pin_lvl);
  assign external_count_input = ext_lvl;
endmodule : pin_model
`default_nettype wire

// File: tb/tb.sv
`include "counter_array_regs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] a_mode = `CA_ADDR_MODE;
  localparam logic [7:0] a_ctrl = `CA_ADDR_CTRL;
  localparam logic [7:0] a_cnt = `CA_ADDR_CNT;
  localparam logic [7:0] a_mm = `CA_ADDR_MMODE0;
  localparam logic [7:0] a_st = `CA_ADDR_STORE0;
  logic sys_clk, rst_n, clk_en, cpu_idle, timer0_overflow, ext_lvl, irq, module4_guard_hit;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, c;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, external_count_input;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0] module_pin_in, module_pin_out, module_pin_oe, pin_lvl;
  int n_mismatch, n_checks, cyc, guard_cnt;

  counter_array #(.N_MOD(5)) u_dut (.sys_clk, .rst_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_idle, .timer0_overflow,
    .external_count_input, .module_pin_in, .module_pin_out, .module_pin_oe, .irq,
    .module4_guard_hit);
  pin_model u_pins (.pin_lvl, .ext_lvl, .module_pin_out, .module_pin_oe, .module_pin_in,
    .external_count_input);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  // generous ceiling, the run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (module4_guard_hit === 1'b1) guard_cnt <= guard_cnt + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
    if (nm != "") chk(nm, rd, e);
  endtask : rc

  initial begin
    {rst_n, cpu_idle, timer0_overflow, ext_lvl, pin_lvl, cyc, guard_cnt} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, n_mismatch, n_checks} = '0;
    clk_en = 1'b1;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rc("ctrl_rst", a_ctrl, 32'h0);
    rc("mode_rst", a_mode, 32'h0);
    rc("bad_data", 8'h80, 32'h0);
    chk("bad_resp", {30'h0, rsp}, 32'h2);
    clk_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    clk_en <= 1'b1;
    @(posedge sys_clk);
    for (int s = 2; s < 4; s++) begin
      wr(a_mode, s << 1);
      wr(a_cnt, 32'h0);
      wr(a_ctrl, 32'h40);
      repeat (5) begin
        timer0_overflow <= (s == 2);
        ext_lvl <= (s == 3);
        @(posedge sys_clk);
        timer0_overflow <= 1'b0;
        @(posedge sys_clk);
        ext_lvl <= 1'b0;
        repeat (2) @(posedge sys_clk);
      end
      wr(a_ctrl, 32'h0);
      rc("src_cnt", a_cnt, 32'h5);
    end
    wr(a_mode, 32'h3);
    wr(a_cnt, 32'hfffe);
    wr(a_ctrl, 32'h40);
    repeat (20) @(posedge sys_clk);
    chk("ovf_irq", {31'h0, irq}, 32'h1);
    rc("ovf_flag", a_ctrl, 32'hc0);
    wr(a_ctrl, 32'h40);
    rc("ovf_clr", a_ctrl, 32'h40);
    wr(a_mode, 32'h82);
    cpu_idle <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rc("", a_cnt, 32'h0);
    c = rd;
    repeat (20) @(posedge sys_clk);
    rc("idle_cnt", a_cnt, c);
    cpu_idle <= 1'b0;
    wr(a_ctrl, 32'h0);
    // software timer on 0, fast output on 1, guard on 4
    for (int m = 0; m < 5; m += 1) wr(a_st + 8'(4 * m), 32'h10);
    wr(a_mm, 32'h49);
    wr(a_mm + 8'h4, 32'h4c);
    wr(a_mm + 8'h10, 32'h48);
    wr(a_mode, 32'h42);
    wr(a_cnt, 32'h0);
    wr(a_ctrl, 32'h40);
    repeat (100) @(posedge sys_clk);
    wr(a_ctrl, 32'h1f);
    rc("hit_flags", a_ctrl, 32'h13);
    chk("hit_pin", {30'h0, module_pin_oe[1], module_pin_out[1]}, 32'h3);
    chk("hit_irq", {31'h0, irq}, 32'h1);
    chk("guard_cnt", guard_cnt, 32'h1);
    wr(a_ctrl, 32'h0);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    wr(a_mm + 8'h8, 32'h20);
    wr(a_mm + 8'hc, 32'h10);
    wr(a_cnt, 32'h1234);
    pin_lvl <= 5'h0c;
    repeat (4) @(posedge sys_clk);
    wr(a_cnt, 32'h5678);
    pin_lvl <= 5'h00;
    repeat (4) @(posedge sys_clk);
    rc("cap_rise", a_st + 8'h8, 32'h1234);
    rc("cap_fall", a_st + 8'hc, 32'h5678);
    rc("cap_flags", a_ctrl, 32'h0c);
    wr(a_mm, 32'h42);
    wr(a_st, 32'h8040);
    wr(a_cnt, 32'h30);
    repeat (4) @(posedge sys_clk);
    chk("pwm_low", {31'h0, module_pin_out[0]}, 32'h0);
    wr(a_cnt, 32'h50);
    repeat (4) @(posedge sys_clk);
    chk("pwm_high", {31'h0, module_pin_out[0]}, 32'h1);
    wr(a_mode, 32'h0);
    wr(a_cnt, 32'hff);
    wr(a_ctrl, 32'h40);
    repeat (30) @(posedge sys_clk);
    wr(a_ctrl, 32'h0);
    rc("pwm_reload", a_st, 32'h8080);
    chk("pwm_wrap", {31'h0, module_pin_out[0]}, 32'h0);
    rc("", a_cnt, 32'h0);
    chk("div12_rate", {31'h0, rd >= 32'h101 && rd <= 32'h104}, 32'h1);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
